/* File: rtl/boot_flash_byte_port.sv */
// How it works
// - select only matters in four-LED mode
// - select set: pin carries flash address 16
// - select clear: pin carries duplex/collision LED
// - read go cleared once data byte loaded
// - write go cleared when write completes
// - address bits 24:8, data 7:0, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "boot_flash_regs.svh"
module boot_flash_byte_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic csr_sel,
   input wire logic csr_wr,
   input wire logic [7:0] csr_addr,
   input wire logic [31:0] csr_wdata,
   output logic [31:0] csr_rdata,
   // led mode
   input wire logic four_led_config,
   input wire logic duplex_collision_led,
   // flash pins
   output boot_flash_pkg::flash_pins_t flash_pins,
   output logic flash_address_line_sixteen,
   input wire logic [7:0] flash_data_in
);
   localparam logic [2:0] RD_LOAD = 3'(`FLASH_RD_CYC + `FLASH_SYNC_STAGES);
   localparam logic [2:0] WE_LOAD = 3'(`FLASH_WE_CYC - 1);

   boot_flash_pkg::flash_state_t state_reg;
   boot_flash_pkg::flash_state_t state_next;
   logic [2:0] cnt_reg;
   logic flash_hi_addr_pin_select_reg;
   logic rd_go_reg;
   logic wr_go_reg;
   logic [16:0] addr_reg;
   logic [7:0] data_reg;
   logic [7:0] sync_data;

   // decode
   wire hit = csr_sel && (csr_addr == `FLASH_PORT_OFFSET);
   wire sw_wr = hit && csr_wr;
   wire sw_rd = hit && !csr_wr;
   wire idle = (state_reg == boot_flash_pkg::ST_IDLE);
   wire start_rd = idle && rd_go_reg;
   wire start_wr = idle && wr_go_reg && !rd_go_reg;
   wire rd_done = (state_reg == boot_flash_pkg::ST_READ) && (cnt_reg == 3'h0);
   wire wr_done = (state_reg == boot_flash_pkg::ST_HOLD);
   wire fields_wr = sw_wr && idle;
   wire shared_next = (four_led_config && flash_hi_addr_pin_select_reg) ? addr_reg[16]
                      : duplex_collision_led;
   wire [31:0] port_word = {flash_hi_addr_pin_select_reg, 3'h0, rd_go_reg, wr_go_reg, 1'b0,
                            addr_reg, data_reg};

   flash_data_sync #(.W(8)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d_in(flash_data_in),
      .d_out(sync_data)
   );

   always_comb
   begin
      case (state_reg)
         boot_flash_pkg::ST_IDLE:
            state_next = start_rd ? boot_flash_pkg::ST_READ
                         : (start_wr ? boot_flash_pkg::ST_WRITE : boot_flash_pkg::ST_IDLE);
         boot_flash_pkg::ST_READ:
            state_next = rd_done ? boot_flash_pkg::ST_IDLE : boot_flash_pkg::ST_READ;
         boot_flash_pkg::ST_WRITE:
            state_next = (cnt_reg == 3'h0) ? boot_flash_pkg::ST_HOLD : boot_flash_pkg::ST_WRITE;
         boot_flash_pkg::ST_HOLD:
            state_next = boot_flash_pkg::ST_IDLE;
         default:
            state_next = boot_flash_pkg::ST_IDLE;
      endcase
   end

   // sequencer
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= boot_flash_pkg::ST_IDLE;
         cnt_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (start_rd)
            cnt_reg <= RD_LOAD;
         else if (start_wr)
            cnt_reg <= WE_LOAD;
         else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
      end
   end

   // port register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         flash_hi_addr_pin_select_reg <= `FLASH_SEL_RESET;
         rd_go_reg <= 1'b0;
         wr_go_reg <= 1'b0;
         addr_reg <= `FLASH_ADDR_RESET;
         data_reg <= `FLASH_DATA_RESET;
      end
      else
      begin
         if (sw_wr)
            flash_hi_addr_pin_select_reg <= csr_wdata[`FLASH_SEL_BIT];
         if (fields_wr)
         begin
            rd_go_reg <= csr_wdata[`FLASH_RD_GO_BIT];
            wr_go_reg <= csr_wdata[`FLASH_WR_GO_BIT];
            addr_reg <= csr_wdata[`FLASH_ADDR_HI:`FLASH_ADDR_LO];
            data_reg <= csr_wdata[`FLASH_DATA_HI:`FLASH_DATA_LO];
         end
         else
         begin
            if (rd_done)
            begin
               data_reg <= sync_data;
               rd_go_reg <= 1'b0;
            end
            if (wr_done)
               wr_go_reg <= 1'b0;
         end
      end
   end

   // pins and readback
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         flash_pins <= '{addr: 16'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dout: 8'h00, doe: 1'b0};
         flash_address_line_sixteen <= 1'b0;
         csr_rdata <= 32'h0000_0000;
      end
      else
      begin
         flash_address_line_sixteen <= shared_next;
         csr_rdata <= sw_rd ? port_word : 32'h0000_0000;
         if (start_rd || start_wr)
         begin
            flash_pins.addr <= addr_reg[15:0];
            flash_pins.dout <= data_reg;
         end
         flash_pins.ce_n <= !(state_next != boot_flash_pkg::ST_IDLE);
         flash_pins.oe_n <= !(state_next == boot_flash_pkg::ST_READ);
         flash_pins.we_n <= !(state_next == boot_flash_pkg::ST_WRITE);
         flash_pins.doe <= (state_next == boot_flash_pkg::ST_WRITE) || (state_next == boot_flash_pkg::ST_HOLD);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_rd_start;
      start_rd && !sw_wr;
   endsequence
   sequence s_wr_start;
      start_wr && !sw_wr;
   endsequence

   property p_pin_addr;
      four_led_config && flash_hi_addr_pin_select_reg |=> flash_address_line_sixteen == $past(addr_reg[16]);
   endproperty
   a_pin_addr: assert property (p_pin_addr) else $error("shared pin not address 16");
   property p_pin_led;
      four_led_config && !flash_hi_addr_pin_select_reg |=> flash_address_line_sixteen == $past(duplex_collision_led);
   endproperty
   a_pin_led: assert property (p_pin_led) else $error("shared pin not led");
   property p_pin_nomode;
      !four_led_config |=> flash_address_line_sixteen == $past(duplex_collision_led);
   endproperty
   a_pin_nomode: assert property (p_pin_nomode) else $error("select acted outside four-led mode");
   property p_rd_clear;
      s_rd_start |-> rd_go_reg [*7] ##1 !rd_go_reg;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read go not cleared on time");
   property p_rd_data;
      rd_done && !sw_wr |=> data_reg == $past(sync_data) && !flash_pins.oe_n == 1'b0;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read byte not loaded");
   property p_wr_clear;
      s_wr_start |=> !flash_pins.we_n [*2] ##1 flash_pins.we_n ##1 !wr_go_reg;
   endproperty
   a_wr_clear: assert property (p_wr_clear) else $error("write sequence wrong");
   property p_fields;
      fields_wr |=> addr_reg == $past(csr_wdata[24:8]) && data_reg == $past(csr_wdata[7:0]);
   endproperty
   a_fields: assert property (p_fields) else $error("port fields not stored");
   property p_sel_write;
      sw_wr |=> flash_hi_addr_pin_select_reg == $past(csr_wdata[`FLASH_SEL_BIT]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("pin select not stored");
   property p_busy_refuse;
      sw_wr && !idle && !rd_done |=> $stable(addr_reg) && $stable(data_reg);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("fields changed while busy");
   property p_rd_pins;
      !flash_pins.oe_n |-> !flash_pins.ce_n && flash_pins.we_n && !flash_pins.doe;
   endproperty
   a_rd_pins: assert property (p_rd_pins) else $error("read strobes clash");
   property p_wr_pins;
      !flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n && flash_pins.doe;
   endproperty
   a_wr_pins: assert property (p_wr_pins) else $error("write strobes clash");
   property p_readback;
      sw_rd |=> csr_rdata[`FLASH_ADDR_HI:`FLASH_ADDR_LO] == $past(addr_reg)
                && csr_rdata[`FLASH_DATA_HI:`FLASH_DATA_LO] == $past(data_reg);
   endproperty
   a_readback: assert property (p_readback) else $error("port word fields wrong");
   property p_access_addr;
      start_rd || start_wr |=> flash_pins.addr == $past(addr_reg[15:0]) && flash_pins.dout == $past(data_reg);
   endproperty
   a_access_addr: assert property (p_access_addr) else $error("access address not on pins");
endmodule
`default_nettype wire

/* File: rtl/boot_flash_pkg.sv */
package boot_flash_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_HOLD = 2'b11
   } flash_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [7:0] dout;
      logic doe;
   } flash_pins_t;

endpackage

/* File: rtl/boot_flash_regs.svh */
`ifndef BOOT_FLASH_REGS_SVH
`define BOOT_FLASH_REGS_SVH

`define FLASH_PORT_OFFSET 8'hA0
`define FLASH_SEL_BIT 31
`define FLASH_RD_GO_BIT 27
`define FLASH_WR_GO_BIT 26
`define FLASH_ADDR_HI 24
`define FLASH_ADDR_LO 8
`define FLASH_DATA_HI 7
`define FLASH_DATA_LO 0
`define FLASH_SEL_RESET 1'b1
`define FLASH_ADDR_RESET 17'h0_0000
`define FLASH_DATA_RESET 8'h00
`define CLK_PERIOD_NS 50
`define FLASH_RD_ACCESS_NS 150
`define FLASH_WE_PULSE_NS 100
`define FLASH_SYNC_STAGES 2
`define FLASH_RD_CYC ((`FLASH_RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_WE_CYC ((`FLASH_WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/flash_data_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_data_sync #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] d_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         d_out <= '0;
      end
      else
      begin
         meta_reg <= d_in;
         d_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* File: test/boot_flash_byte_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_flash_byte_port_tb;
   logic core_clk, rst, csr_sel, csr_wr, four_led_config, duplex_collision_led, rd_hit;
   logic [7:0] csr_addr, flash_data_in;
   logic [31:0] csr_wdata, csr_rdata, w;
   logic [31:0] exp_q [$];
   logic [31:0] seed = 32'h0000_0009;
   logic flash_address_line_sixteen;
   boot_flash_pkg::flash_pins_t flash_pins;
   int i, cyc, num_errors = 0, n_checks = 0;
   boot_flash_byte_port u_boot_flash_byte_port (.core_clk(core_clk), .rst(rst), .csr_sel(csr_sel),
      .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
      .four_led_config(four_led_config), .duplex_collision_led(duplex_collision_led),
      .flash_pins(flash_pins), .flash_address_line_sixteen(flash_address_line_sixteen),
      .flash_data_in(flash_data_in));
   flash_model u_flash_model (.core_clk(core_clk), .pins(flash_pins), .data_out(flash_data_in));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic test_done();
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic [28:0] e, input logic [28:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk);
      csr_sel = 1'b1;
      csr_wr = wr;
      csr_addr = a;
      csr_wdata = d;
      @(negedge core_clk);
      csr_sel = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 32'h0000_0000);
   endtask
   // watcher compares each read answer with the oldest note
   always @(posedge core_clk)
      rd_hit <= csr_sel && !csr_wr;
   always @(negedge core_clk)
      if (rd_hit === 1'b1)
         chk(exp_q.pop_front(), csr_rdata);
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         test_done();
      end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial
   begin
      rst = 1'b1;
      csr_sel = 1'b0;
      csr_wr = 1'b0;
      csr_addr = 8'h00;
      csr_wdata = 32'h0000_0000;
      four_led_config = 1'b0;
      duplex_collision_led = 1'b0;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      rd(8'hA0, 32'h8000_0000);
      rd(8'hA4, 32'h0000_0000);
      // pin select against led mode, reserved bits read zero
      for (i = 0; i < 8; i++)
      begin
         w = (xs() & 32'h73FF_FFFF) | {i[2], 31'h0};
         four_led_config = i[0];
         duplex_collision_led = i[1];
         acc(1'b1, 8'hA0, w);
         rd(8'hA0, w & 32'h81FF_FFFF);
         chk_pin({(i[0] && w[31]) ? w[24] : i[1], 16'h0000, 3'h7, 8'h00, 1'h0},
                 {flash_address_line_sixteen, flash_pins});
      end
      // flash write, then read back through a cleared data field
      for (i = 0; i < 4; i++)
      begin
         w = (xs() & 32'h01FF_FFFF) | 32'h8000_0000;
         acc(1'b1, 8'hA0, w | 32'h0400_0000);
         rd(8'hA0, w | 32'h0400_0000);
         chk_pin({w[24:8], 3'h2, w[7:0], 1'h1}, {flash_address_line_sixteen, flash_pins});
         repeat (6) @(negedge core_clk);
         chk_pin({w[24:8], 3'h7, w[7:0], 1'h0}, {flash_address_line_sixteen, flash_pins});
         rd(8'hA0, w);
         acc(1'b1, 8'hA0, (w & 32'h81FF_FF00) | 32'h0800_0000);
         acc(1'b1, 8'hA0, w ^ 32'h05FF_FFFF);
         rd(8'hA0, (w & 32'h81FF_FF00) | 32'h0800_0000);
         chk_pin({w[24:8], 3'h1, 8'h00, 1'h0}, {flash_address_line_sixteen, flash_pins});
         repeat (8) @(negedge core_clk);
         rd(8'hA0, w);
      end
      repeat (3) @(negedge core_clk);
      test_done();
   end
endmodule
`default_nettype wire

/* File: test/flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_model (
   // clock
   input wire logic core_clk,
   // flash pins
   input wire boot_flash_pkg::flash_pins_t pins,
   output logic [7:0] data_out
);
   logic [7:0] mem [65536];
   logic [7:0] last = 8'h00;
   // released bus shows a changing pattern
   assign data_out = (!pins.ce_n && !pins.oe_n) ? mem[pins.addr] : ~last;
   always @(posedge core_clk)
      last <= data_out;
   always @(posedge pins.we_n)
      if (!pins.ce_n && pins.doe)
         mem[pins.addr] <= pins.dout;
endmodule
`default_nettype wire
